//--- hw/bio_pkg.sv
// Purpose: Shared constants for the bytewise I/O port block.
// Assumes: Eight-bit data-space bus, five ports A to E.
// Notes:   Addresses are data-space byte addresses.
package bio_pkg;
	localparam int          BIO_PORTS    = 5;
	localparam int          BIO_WIDTH    = 8;
	localparam int          BIO_SYNC     = 3;
	// ==========================================================
	// Data-space addresses, ports A, B, C, D, E.
	localparam logic [7:0]  BIO_DATA_A   = 8'hC0;
	localparam logic [7:0]  BIO_DATA_B   = 8'hC1;
	localparam logic [7:0]  BIO_DATA_C   = 8'hC2;
	localparam logic [7:0]  BIO_DATA_D   = 8'hC3;
	localparam logic [7:0]  BIO_DATA_E   = 8'hFC;
	localparam logic [7:0]  BIO_DIR_A    = 8'hC4;
	localparam logic [7:0]  BIO_DIR_B    = 8'hC5;
	localparam logic [7:0]  BIO_DIR_C    = 8'hC6;
	localparam logic [7:0]  BIO_DIR_D    = 8'hC7;
	localparam logic [7:0]  BIO_DIR_E    = 8'hFD;
	localparam logic [7:0]  BIO_OPT_A    = 8'hCC;
	localparam logic [7:0]  BIO_OPT_B    = 8'hCD;
	localparam logic [7:0]  BIO_OPT_C    = 8'hCE;
	localparam logic [7:0]  BIO_OPT_D    = 8'hCF;
	localparam logic [7:0]  BIO_OPT_E    = 8'hFE;
	localparam logic [7:0]  BIO_POL_ADDR = 8'hDA;
	// ==========================================================
	// Polarity register bit positions per port.
	localparam int          BIO_POL_B    = 0;
	localparam int          BIO_POL_A    = 1;
	localparam int          BIO_POL_C    = 2;
	localparam int          BIO_POL_D    = 3;
	localparam int          BIO_POL_E    = 4;
	localparam logic [7:0]  BIO_POL_MASK = 8'h1F;
	localparam logic [7:0]  BIO_RST      = 8'h00;
	// ==========================================================
	// Trigger modes applied by the interrupt configuration input.
	typedef enum logic [1:0] {
		BIO_TRIG_FALL  = 2'h0,
		BIO_TRIG_RISE  = 2'h1,
		BIO_TRIG_LOW   = 2'h2,
		BIO_TRIG_HIGH  = 2'h3
	} bio_trig_e;
endpackage

//--- hw/bio_line.sv
// Purpose: One port byte: pin synchroniser, mode decode and interrupt detect.
// Assumes: Register bits come from the same clock; pins are asynchronous.
// Notes:   All outputs are registered.
`timescale 1ns/1ns
`default_nettype none
module bio_line
	import bio_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [BIO_WIDTH-1:0] latch,
	input  wire logic [BIO_WIDTH-1:0] dir,
	input  wire logic [BIO_WIDTH-1:0] opt,
	input  wire logic [1:0]           trig,
	input  wire logic [BIO_WIDTH-1:0] pin_in,
	output logic      [BIO_WIDTH-1:0] pin_level,
	output logic      [BIO_WIDTH-1:0] pin_out,
	output logic      [BIO_WIDTH-1:0] pin_oe,
	output logic      [BIO_WIDTH-1:0] pull_up,
	output logic      [BIO_WIDTH-1:0] analog_sel,
	output logic                      irq
);
	// ==========================================================
	// Pin synchroniser: stage one feeds stage two only.
	logic [BIO_WIDTH-1:0] sync1_ff;
	logic [BIO_WIDTH-1:0] sync2_ff;
	logic [BIO_WIDTH-1:0] sync3_ff;
	logic [BIO_WIDTH-1:0] lvl_ff;
	logic [BIO_WIDTH-1:0] irq_en;
	logic [BIO_WIDTH-1:0] nxt_lvl;
	logic                 nxt_irq;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= BIO_RST;
			sync2_ff <= BIO_RST;
			sync3_ff <= BIO_RST;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end
	// A change counts once stages two and three agree, rejecting one-cycle glitches.
	always_comb begin
		for (int i = 0; i < BIO_WIDTH; i++) begin
			nxt_lvl[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : lvl_ff[i];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_ff <= BIO_RST;
		end else begin
			lvl_ff <= nxt_lvl;
		end
	end
	assign pin_level = lvl_ff;
	// ==========================================================
	// Mode decode, effective the cycle after a register change.
	assign irq_en = ~dir & opt & ~latch;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out    <= BIO_RST;
			pin_oe     <= BIO_RST;
			pull_up    <= BIO_RST;
			analog_sel <= BIO_RST;
		end else begin
			pin_out    <= dir & opt & latch;
			pin_oe     <= dir & (opt | ~latch);
			pull_up    <= ~dir & ~latch;
			analog_sel <= ~dir & opt & latch;
		end
	end
	// ==========================================================
	// Interrupt detect over lines routed to the interrupt logic.
	always_comb begin
		nxt_irq = 1'b0;
		for (int i = 0; i < BIO_WIDTH; i++) begin
			if (irq_en[i]) begin
				case (trig)
					BIO_TRIG_FALL: nxt_irq = nxt_irq | (lvl_ff[i] & ~nxt_lvl[i]);
					BIO_TRIG_RISE: nxt_irq = nxt_irq | (~lvl_ff[i] & nxt_lvl[i]);
					BIO_TRIG_LOW:  nxt_irq = nxt_irq | ~nxt_lvl[i];
					default:       nxt_irq = nxt_irq | nxt_lvl[i];
				endcase
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= nxt_irq;
		end
	end
endmodule
`default_nettype wire

//--- hw/bio_port.sv
// Purpose: Five bytewise I/O ports with data, direction and option registers.
// Assumes: Single-cycle data-space bus: addr, wdata, wr, rd; rdata valid next cycle.
// Notes:   Level triggering is chosen by the level_sel input per port.
//
// What this block does
// - Three eight-bit registers per port, bit per line.
// - Input lines read back the sampled pin.
// - Data writes always update the latch.
// - Direction bit: zero input, one output.
// - Reset clears all registers: pull-up inputs.
// - Dir0 opt0 data0: input with pull-up.
// - Dir0 opt0 data1: high-impedance input.
// - Dir0 opt1 data0: pull-up input with interrupt.
// - Dir0 opt1 data1: analog input to multiplexer.
// - Dir1 opt0: open-drain, low when latch zero.
// - Dir1 opt1: push-pull output.
// - Outputs drive the latch value.
// - Interrupt triggers falling, rising, low or high level.
// - Registers readable and writable as memory.
// - Polarity bit inverts port trigger sense.
// - Data registers at C0h-C3h and FCh.
`timescale 1ns/1ns
`default_nettype none
module bio_port
	import bio_pkg::*;
(
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire logic [7:0]                     addr,
	input  wire logic [7:0]                     wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	input  wire logic [BIO_PORTS-1:0]           level_sel,
	input  wire logic [BIO_PORTS*BIO_WIDTH-1:0] pin_in,
	output logic      [7:0]                     rdata,
	output logic                                rdata_hit,
	output logic      [BIO_PORTS*BIO_WIDTH-1:0] pin_out,
	output logic      [BIO_PORTS*BIO_WIDTH-1:0] pin_oe,
	output logic      [BIO_PORTS*BIO_WIDTH-1:0] pull_up,
	output logic      [BIO_PORTS*BIO_WIDTH-1:0] analog_sel,
	output logic      [BIO_PORTS-1:0]           irq
);
	// ==========================================================
	// Register storage, index 0..4 for ports A..E.
	logic [BIO_WIDTH-1:0] latch_ff [BIO_PORTS];
	logic [BIO_WIDTH-1:0] dir_ff   [BIO_PORTS];
	logic [BIO_WIDTH-1:0] opt_ff   [BIO_PORTS];
	logic [7:0]           interrupt_polarity_select_ff;
	logic [BIO_WIDTH-1:0] level    [BIO_PORTS];
	logic [7:0]           nxt_rdata;
	logic                 nxt_hit;
	logic [2:0]           sel_port;
	logic [1:0]           sel_kind;
	logic                 sel_pol;
	logic                 sel_any;

	// ==========================================================
	// Address decode. Kind 0 data, 1 direction, 2 option.
	always_comb begin
		sel_port = 3'h0;
		sel_kind = 2'h0;
		sel_pol  = 1'b0;
		sel_any  = 1'b1;
		if (addr == BIO_DATA_A) begin
			sel_port = 3'h0;
			sel_kind = 2'h0;
		end else if (addr == BIO_DATA_B) begin
			sel_port = 3'h1;
			sel_kind = 2'h0;
		end else if (addr == BIO_DATA_C) begin
			sel_port = 3'h2;
			sel_kind = 2'h0;
		end else if (addr == BIO_DATA_D) begin
			sel_port = 3'h3;
			sel_kind = 2'h0;
		end else if (addr == BIO_DATA_E) begin
			sel_port = 3'h4;
			sel_kind = 2'h0;
		end else if (addr == BIO_DIR_A) begin
			sel_port = 3'h0;
			sel_kind = 2'h1;
		end else if (addr == BIO_DIR_B) begin
			sel_port = 3'h1;
			sel_kind = 2'h1;
		end else if (addr == BIO_DIR_C) begin
			sel_port = 3'h2;
			sel_kind = 2'h1;
		end else if (addr == BIO_DIR_D) begin
			sel_port = 3'h3;
			sel_kind = 2'h1;
		end else if (addr == BIO_DIR_E) begin
			sel_port = 3'h4;
			sel_kind = 2'h1;
		end else if (addr == BIO_OPT_A) begin
			sel_port = 3'h0;
			sel_kind = 2'h2;
		end else if (addr == BIO_OPT_B) begin
			sel_port = 3'h1;
			sel_kind = 2'h2;
		end else if (addr == BIO_OPT_C) begin
			sel_port = 3'h2;
			sel_kind = 2'h2;
		end else if (addr == BIO_OPT_D) begin
			sel_port = 3'h3;
			sel_kind = 2'h2;
		end else if (addr == BIO_OPT_E) begin
			sel_port = 3'h4;
			sel_kind = 2'h2;
		end else if (addr == BIO_POL_ADDR) begin
			sel_pol = 1'b1;
		end else begin
			sel_any = 1'b0;
		end
	end

	// ==========================================================
	// Register writes.
	// Each register kind has its own process, so a write touches one array only.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < BIO_PORTS; p++) begin
				latch_ff[p] <= BIO_RST;
			end
		end else if (wr && sel_any && !sel_pol && sel_kind == 2'h0) begin
			latch_ff[sel_port] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < BIO_PORTS; p++) begin
				dir_ff[p] <= BIO_RST;
			end
		end else if (wr && sel_any && !sel_pol && sel_kind == 2'h1) begin
			dir_ff[sel_port] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < BIO_PORTS; p++) begin
				opt_ff[p] <= BIO_RST;
			end
		end else if (wr && sel_any && !sel_pol && sel_kind == 2'h2) begin
			opt_ff[sel_port] <= wdata;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interrupt_polarity_select_ff <= BIO_RST;
		end else if (wr && sel_pol) begin
			interrupt_polarity_select_ff <= wdata & BIO_POL_MASK;
		end
	end

	// ==========================================================
	// Readback. Input lines show the pin, output lines the latch.
	always_comb begin
		nxt_rdata = 8'h00;
		nxt_hit   = rd & sel_any;
		if (!sel_any) begin
			nxt_rdata = 8'h00;
		end else if (sel_pol) begin
			nxt_rdata = interrupt_polarity_select_ff;
		end else if (sel_kind == 2'h0) begin
			nxt_rdata = (dir_ff[sel_port] & latch_ff[sel_port])
				| (~dir_ff[sel_port] & level[sel_port]);
		end else if (sel_kind == 2'h1) begin
			nxt_rdata = dir_ff[sel_port];
		end else begin
			nxt_rdata = opt_ff[sel_port];
		end
	end
	// Unmapped addresses read as zero with rdata_hit low.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata     <= 8'h00;
			rdata_hit <= 1'b0;
		end else begin
			rdata     <= rd ? nxt_rdata : 8'h00;
			rdata_hit <= nxt_hit;
		end
	end

	// ==========================================================
	// Per-port line logic. Polarity bit order is B, A, C, D, E.
	localparam int POL_IDX [BIO_PORTS] = '{
		BIO_POL_A,
		BIO_POL_B,
		BIO_POL_C,
		BIO_POL_D,
		BIO_POL_E
	};
	genvar g;
	generate
		for (g = 0; g < BIO_PORTS; g++) begin : g_port
			logic [1:0] trig;
			// Polarity inverts edge or level sense; level_sel picks level over edge.
			assign trig = {level_sel[g], interrupt_polarity_select_ff[POL_IDX[g]]};
			bio_line u_line (
				.clk        (clk),
				.rst        (rst),
				.latch      (latch_ff[g]),
				.dir        (dir_ff[g]),
				.opt        (opt_ff[g]),
				.trig       (trig),
				.pin_in     (pin_in[g*BIO_WIDTH +: BIO_WIDTH]),
				.pin_level  (level[g]),
				.pin_out    (pin_out[g*BIO_WIDTH +: BIO_WIDTH]),
				.pin_oe     (pin_oe[g*BIO_WIDTH +: BIO_WIDTH]),
				.pull_up    (pull_up[g*BIO_WIDTH +: BIO_WIDTH]),
				.analog_sel (analog_sel[g*BIO_WIDTH +: BIO_WIDTH]),
				.irq        (irq[g])
			);
		end
	endgenerate
endmodule
`default_nettype wire

//--- test/bio_port_monitor.sv
// Purpose: Assertions on the port block bus answers and pin outputs.
// Assumes: Sees only the top module ports.
// Notes:   Bound to every port block below.
`timescale 1ns/1ns
`default_nettype none
module bio_port_monitor
	import bio_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        rdata_hit,
	input wire logic [39:0] pin_out,
	input wire logic [39:0] pin_oe,
	input wire logic [39:0] pull_up,
	input wire logic [39:0] analog_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// Direction clear, then two cycles to the pins.
	sequence s_dir_clr;
		wr && !rd && addr == BIO_DIR_A && wdata == 8'h00;
	endsequence
	a_read_answer: assert property (rd && addr == BIO_OPT_E |=> rdata_hit)
		else $error("mapped read not answered");
	a_unmapped_quiet: assert property (rd && addr == 8'h00 |=> !rdata_hit)
		else $error("unmapped read answered");
	a_pol_unused: assert property (rd && addr == BIO_POL_ADDR |=> rdata[7:5] == 3'h0)
		else $error("unused polarity bits read set");
	a_drive_needs_oe: assert property ((pin_out & ~pin_oe) == 40'h0)
		else $error("drive value without enable");
	a_pullup_input: assert property ((pull_up & pin_oe) == 40'h0)
		else $error("pull-up on driven line");
	a_analog_alone: assert property ((analog_sel & (pull_up | pin_oe)) == 40'h0)
		else $error("analog line also pulled or driven");
	a_dir_clear: assert property (s_dir_clr |=> ##1 pin_oe[7:0] == 8'h00)
		else $error("cleared direction still drives");
	a_reset_inputs: assert property ($fell(rst) |-> pin_oe == 40'h0 && analog_sel == 40'h0)
		else $error("line not input after reset");
endmodule
bind bio_port bio_port_monitor u_mon (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
	.rdata_hit, .pin_out, .pin_oe, .pull_up, .analog_sel);
`default_nettype wire

//--- test/bio_pins_model.sv
// Purpose: External pins seen by the port block.
// Assumes: The block's own drive beats any outside driver.
// Notes:   A line nobody drives or pulls toggles each cycle.
`timescale 1ns/1ns
`default_nettype none
module bio_pins_model (
	input  wire logic        clk,
	input  wire logic [39:0] pin_out,
	input  wire logic [39:0] pin_oe,
	input  wire logic [39:0] pull_up,
	input  wire logic [39:0] ext_val,
	input  wire logic [39:0] ext_en,
	output logic      [39:0] pin_in
);
	logic [39:0] float_ff = 40'h0;
	always @(posedge clk) begin
		float_ff <= ~float_ff;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_up | float_ff));
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for the bytewise port block.
// Assumes: Read data answers one cycle after the read strobe.
// Notes:   Port A carries the mode table and the trigger cases.
`timescale 1ns/1ns
`default_nettype none
module tb
	import bio_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [4:0]  level_sel = 5'h00;
	logic [39:0] ext_val = 40'h0;
	logic [39:0] ext_en = 40'h0;
	wire  [39:0] pin_in, pin_out, pin_oe, pull_up, analog_sel;
	wire  [7:0]  rdata;
	wire         rdata_hit;
	wire  [4:0]  irq;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [7:0]  dirs [5] = '{BIO_DIR_A, BIO_DIR_B, BIO_DIR_C, BIO_DIR_D, BIO_DIR_E};
	logic [7:0]  opts [5] = '{BIO_OPT_A, BIO_OPT_B, BIO_OPT_C, BIO_OPT_D, BIO_OPT_E};
	logic [7:0]  dats [5] = '{BIO_DATA_A, BIO_DATA_B, BIO_DATA_C, BIO_DATA_D, BIO_DATA_E};
	bio_port u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .level_sel, .pin_in, .rdata,
		.rdata_hit, .pin_out, .pin_oe, .pull_up, .analog_sel, .irq);
	bio_pins_model u_pins (.clk, .pin_out, .pin_oe, .pull_up, .ext_val, .ext_en, .pin_in);
	initial begin
		forever #4 clk = ~clk;
	end
	// ==========================================
	// Bus tasks and checks.
	task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a, logic hit, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("read", 40'({rdata_hit, rdata}), 40'({hit, e}));
	endtask
	// Mode settles first; a level request already active before the pin change still shows in seen.
	task automatic trig(logic lvl, logic pol, logic pin, int b, logic [1:0] e);
		logic seen;
		seen = 1'b0;
		wr_reg(BIO_POL_ADDR, (8'(pol) << BIO_POL_A) & BIO_POL_MASK);
		level_sel <= {4'h0, lvl};
		repeat (10) @(posedge clk);
		ext_val[b] <= pin;
		repeat (10) begin
			@(posedge clk);
			#1;
			seen = seen | irq[0];
		end
		chk("irq", 40'({seen, irq[0]}), 40'(e));
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			end_sim();
		end
	end
	// ==========================================
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("pull_up", pull_up, {40{1'b1}});
		wr_reg(BIO_DIR_A, 8'h00);
		rd_reg(8'h00, 1'b0, 8'h00);
		wr_reg(BIO_POL_ADDR, 8'hFF);
		rd_reg(BIO_POL_ADDR, 1'b1, BIO_POL_MASK);
		for (int i = 0; i < 5; i++) begin
			rd_reg(dirs[i], 1'b1, 8'h00);
			rd_reg(opts[i], 1'b1, 8'h00);
			rd_reg(dats[i], 1'b1, 8'hFF);
			wr_reg(dirs[i], 8'hA5 ^ 8'(i));
			wr_reg(opts[i], 8'h3C ^ 8'(i));
			rd_reg(dirs[i], 1'b1, 8'hA5 ^ 8'(i));
			rd_reg(opts[i], 1'b1, 8'h3C ^ 8'(i));
		end
		wr_reg(BIO_DIR_B, 8'hFF);
		wr_reg(BIO_OPT_B, 8'hFF);
		wr_reg(BIO_DATA_B, 8'h5A); // whole byte written
		rd_reg(BIO_DATA_B, 1'b1, 8'h5A);
		chk("pin_oe_b", 40'(pin_oe[15:8]), 40'hFF);
		wr_reg(BIO_DATA_A, 8'hAA);
		wr_reg(BIO_DIR_A, 8'hF0);
		wr_reg(BIO_OPT_A, 8'hCC); // one analog line only
		ext_en[7:0] <= 8'hFF;
		ext_val[7:0] <= 8'h27;
		repeat (6) @(posedge clk);
		#1;
		chk("pin_oe_a", 40'(pin_oe[7:0]), 40'hD0);
		chk("pin_out_a", 40'(pin_out[7:0]), 40'h80);
		chk("pull_up_a", 40'(pull_up[7:0]), 40'h05);
		chk("analog_a", 40'(analog_sel[7:0]), 40'h08);
		rd_reg(BIO_DATA_A, 1'b1, 8'hA7);
		trig(1'b0, 1'b0, 1'b0, 2, 2'h2);
		trig(1'b0, 1'b0, 1'b1, 2, 2'h0);
		trig(1'b0, 1'b0, 1'b0, 0, 2'h0);
		trig(1'b0, 1'b1, 1'b0, 2, 2'h0);
		trig(1'b0, 1'b1, 1'b1, 2, 2'h2);
		trig(1'b1, 1'b0, 1'b0, 2, 2'h3);
		trig(1'b1, 1'b0, 1'b1, 2, 2'h2);
		trig(1'b1, 1'b1, 1'b0, 2, 2'h2);
		trig(1'b1, 1'b1, 1'b1, 2, 2'h3);
		chk("irq_bcde", 40'(irq[4:1]), 40'h0);
		end_sim();
	end
endmodule
`default_nettype wire
